// ### aie_add_exec.sv
// Add instruction decode and execute unit with APB register access
//
// Contract
// - A read of a port register takes the pin levels, not the latch.
// - A file write to the first timer clears its assigned prescaler.
// - A program counter change or true test adds a nop cycle.
// - A lone second word of a two-word instruction runs as a nop.
// - Opcode 0000 1111 adds the literal to work and keeps it there.
// - Opcode 0010 01da adds work to file and updates all five flags.
// - Destination bit zero writes work, one writes the file register.
// - Extended set, access bit zero, f up to 5Fh uses indexed offset.
//
// Design decisions made here: the APB slave port and the placing of the registers.
module aie_add_exec (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [aie_pkg::APB_AW-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [aie_pkg::DATA_W-1:0]  port_pins,
	input  wire logic [aie_pkg::DATA_W-1:0]  dmem_rdata,
	output aie_pkg::aie_dmem_s               dmem_req,
	output logic                             timer_presc_clr,
	output logic                             busy
);
	import aie_pkg::*;

	logic [1:0]         ctrl_r;
	logic [DATA_W-1:0]  work_r;
	aie_flags_s         flags_r;
	logic [BANK_W-1:0]  bank_r;
	logic [ADDR_W-1:0]  idx_r;
	logic [INSTR_W-1:0] instr_r;
	aie_state_e         state_r;
	aie_state_e         state_nxt;
	aie_class_e         cls_r;
	logic               expect2_r;
	logic               run_nop_r;
	logic               flush_r;
	logic [ADDR_W-1:0]  addr_r;
	logic [DATA_W-1:0]  opnd_r;
	logic [DATA_W-1:0]  sum_r;
	aie_flags_s         sflags_r;
	logic               dwe_r;
	logic               clr_r;
	logic [31:0]        prdata_r;

	// Bus decode
	wire apb_wr    = psel && penable && pwrite;
	wire apb_setup = psel && !penable;
	wire hit_ctrl  = (paddr == OFS_CTRL);
	wire hit_work  = (paddr == OFS_WORK);
	wire hit_flags = (paddr == OFS_FLAGS);
	wire hit_bank  = (paddr == OFS_BANK);
	wire hit_idx   = (paddr == OFS_IDX);
	wire hit_instr = (paddr == OFS_INSTR);
	wire hit_state = (paddr == OFS_STATE);
	wire hit_any   = hit_ctrl || hit_work || hit_flags || hit_bank ||
		hit_idx || hit_instr || hit_state;
	wire wr_ctrl   = apb_wr && hit_ctrl;
	wire wr_work   = apb_wr && hit_work;
	wire wr_flags  = apb_wr && hit_flags;
	wire wr_bank   = apb_wr && hit_bank;
	wire wr_idx    = apb_wr && hit_idx;
	wire wr_instr  = apb_wr && hit_instr;

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit_any;
	assign prdata  = prdata_r;

	wire [31:0] state_word = {29'h0000_0000, flush_r, expect2_r,
		(state_r != ST_IDLE)};
	wire [31:0] rd_mux =
		hit_ctrl  ? {30'h0000_0000, ctrl_r} :
		hit_work  ? {24'h00_0000, work_r} :
		hit_flags ? {27'h000_0000, flags_r} :
		hit_bank  ? {28'h000_0000, bank_r} :
		hit_idx   ? {20'h0_0000, idx_r} :
		hit_instr ? {16'h0000, instr_r} :
		hit_state ? state_word : 32'h0000_0000;

	// Quarter phase timing
	logic q_tick;
	wire  start = wr_instr && (state_r == ST_IDLE);
	wire  q1_t  = q_tick && (state_r == ST_Q1);
	wire  q2_t  = q_tick && (state_r == ST_Q2);
	wire  q3_t  = q_tick && (state_r == ST_Q3);
	wire  q4_t  = q_tick && (state_r == ST_Q4);

	aie_qtr_div u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.restart (start),
		.q_tick  (q_tick)
	);

	// Decode of the held word
	wire [7:0]        f_lit    = instr_r[7:0];
	wire              d_bit    = instr_r[BIT_D];
	wire              a_bit    = instr_r[BIT_A];
	wire aie_class_e  dec_cls  = run_nop_r ? CL_NOP : aie_decode(instr_r);
	wire              cond_hit = aie_cond(instr_r[10:8], flags_r);
	wire              take2    = (cls_r == CL_PCJMP) ||
		((cls_r == CL_BRCOND) && cond_hit);
	wire [ADDR_W-1:0] eff      = aie_eff_addr(ctrl_r[CTRL_EXT_BIT], a_bit,
		f_lit, bank_r, idx_r);
	wire              is_port  = (addr_r == PORT_ADDR);
	wire [DATA_W-1:0] file_val = is_port ? port_pins : dmem_rdata;
	wire [DATA_W-1:0] opnd_sel = (cls_r == CL_ADD_LIT) ? f_lit : file_val;
	wire              do_add   = (cls_r == CL_ADD_LIT) ||
		(cls_r == CL_ADD_FILE);
	wire              to_file  = (cls_r == CL_ADD_FILE) && d_bit;
	wire              to_work  = do_add && !to_file;
	wire              tmr_hit  = to_file && (addr_r == TIMER_ADDR) &&
		ctrl_r[CTRL_PSA_BIT];

	logic [DATA_W-1:0] add_sum;
	aie_flags_s        add_flags;

	aie_adder u_add (
		.a     (work_r),
		.b     (opnd_r),
		.sum   (add_sum),
		.flags (add_flags)
	);

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: if (start) state_nxt = ST_Q1;
			ST_Q1:   if (q_tick) state_nxt = ST_Q2;
			ST_Q2:   if (q_tick) state_nxt = ST_Q3;
			ST_Q3:   if (q_tick) state_nxt = ST_Q4;
			ST_Q4:   if (q_tick) state_nxt = take2 ? ST_Q1 : ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Sequencing of nop cycles and second words
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			instr_r   <= INSTR_RST;
			expect2_r <= 1'b0;
			run_nop_r <= 1'b0;
			flush_r   <= 1'b0;
			cls_r     <= CL_NOP;
		end
		else
		begin
			if (start)
			begin
				instr_r   <= pwdata[INSTR_W-1:0];
				run_nop_r <= expect2_r;
				expect2_r <= 1'b0;
			end
			if (q1_t)
				cls_r <= dec_cls;
			if (q4_t)
			begin
				expect2_r <= (cls_r == CL_TWO1ST);
				run_nop_r <= take2;
				flush_r   <= take2;
			end
			else if (start)
				flush_r <= 1'b0;
		end
	end

	// Operand path over the quarters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_r   <= '0;
			opnd_r   <= '0;
			sum_r    <= '0;
			sflags_r <= FLAGS_RST;
		end
		else
		begin
			if (q1_t)
				addr_r <= eff;
			if (q2_t)
				opnd_r <= opnd_sel;
			if (q3_t)
			begin
				sum_r    <= add_sum;
				sflags_r <= add_flags;
			end
		end
	end

	// Architectural state; execution wins over a bus write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r  <= CTRL_RST;
			work_r  <= WORK_RST;
			flags_r <= FLAGS_RST;
			bank_r  <= BANK_RST;
			idx_r   <= IDX_RST;
			dwe_r   <= 1'b0;
			clr_r   <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= pwdata[1:0];
			if (wr_bank)
				bank_r <= pwdata[BANK_W-1:0];
			if (wr_idx)
				idx_r <= pwdata[ADDR_W-1:0];
			if (q4_t && to_work)
				work_r <= sum_r;
			else if (wr_work)
				work_r <= pwdata[DATA_W-1:0];
			if (q4_t && do_add)
				flags_r <= sflags_r;
			else if (wr_flags)
				flags_r <= pwdata[4:0];
			dwe_r <= q4_t && to_file;
			clr_r <= q4_t && tmr_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h0000_0000;
		else if (apb_setup)
			prdata_r <= rd_mux;
	end

	assign dmem_req.we    = dwe_r;
	assign dmem_req.addr  = addr_r;
	assign dmem_req.wdata = sum_r;
	assign timer_presc_clr = clr_r;
	assign busy = (state_r != ST_IDLE);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_add_lit_sum: assert property (
		q4_t && cls_r == CL_ADD_LIT && !wr_work |=>
		work_r == DATA_W'($past(opnd_r) + $past(work_r)))
		else $error("literal add result wrong");
	a_dest_file: assert property (
		q4_t && to_file |=> dmem_req.we && work_r == $past(work_r, 1) &&
		dmem_req.wdata == $past(sum_r))
		else $error("file destination not written");
	a_dest_work: assert property (
		q4_t && cls_r == CL_ADD_FILE && !d_bit |=> !dmem_req.we &&
		work_r == $past(sum_r))
		else $error("work destination not written");
	a_port_pins: assert property (
		q2_t && cls_r == CL_ADD_FILE && is_port |=>
		opnd_r == $past(port_pins))
		else $error("port operand not from pins");
	a_presc_clr: assert property (
		q4_t && tmr_hit |=> timer_presc_clr ##1 !timer_presc_clr)
		else $error("prescaler clear missing");
	a_flush_nop: assert property (
		q4_t && cls_r == CL_PCJMP |=> state_r == ST_Q1 && run_nop_r
		##[1:8] cls_r == CL_NOP)
		else $error("no nop cycle after jump");
	a_second_nop: assert property (
		q1_t && instr_r[15:12] == OPC_SECOND |=> cls_r == CL_NOP)
		else $error("lone second word not a nop");
	a_lofs_addr: assert property (
		q1_t && ctrl_r[CTRL_EXT_BIT] && !a_bit && f_lit <= LOFS_MAX |=>
		addr_r == ADDR_W'($past(idx_r) + ADDR_W'($past(f_lit))))
		else $error("indexed address wrong");
	a_bank_addr: assert property (
		q1_t && a_bit |=> addr_r == {$past(bank_r), $past(f_lit)})
		else $error("banked address wrong");
	a_phase_walk: assert property (
		start |=> state_r == ST_Q1 ##[1:2] state_r == ST_Q2
		##[1:2] state_r == ST_Q3 ##[1:2] state_r == ST_Q4)
		else $error("quarter phases out of order");
	a_flag_load: assert property (
		q4_t && do_add |=> flags_r == $past(sflags_r))
		else $error("flags not updated by add");
	a_branch_nop: assert property (
		q4_t && cls_r == CL_BRCOND && cond_hit |=> busy &&
		state_r == ST_Q1 && run_nop_r)
		else $error("no nop cycle after taken branch");
	a_skip_second: assert property (
		start && expect2_r |=> run_nop_r && !expect2_r)
		else $error("second word not consumed as nop");
	a_nop_no_write: assert property (
		q4_t && cls_r == CL_NOP && !wr_work |=> !dmem_req.we &&
		!timer_presc_clr && work_r == $past(work_r))
		else $error("nop cycle changed state");
endmodule : aie_add_exec

// ### aie_adder.sv
// Eight bit adder with status flag generation
module aie_adder (
	input  wire logic [aie_pkg::DATA_W-1:0] a,
	input  wire logic [aie_pkg::DATA_W-1:0] b,
	output logic [aie_pkg::DATA_W-1:0]      sum,
	output aie_pkg::aie_flags_s             flags
);
	import aie_pkg::*;

	logic [DATA_W:0] full;
	logic [4:0]      low;

	assign full     = {1'b0, a} + {1'b0, b};
	assign low      = {1'b0, a[3:0]} + {1'b0, b[3:0]};
	assign sum      = full[DATA_W-1:0];
	assign flags.c  = full[DATA_W];
	assign flags.digit_carry_flag = low[4];
	assign flags.z  = (full[DATA_W-1:0] == '0);
	assign flags.n  = full[DATA_W-1];
	assign flags.overflow_flag = (a[DATA_W-1] == b[DATA_W-1]) &&
		(full[DATA_W-1] != a[DATA_W-1]);
endmodule : aie_adder

// ### aie_dmem_model.sv
// Data memory model facing the add execute block
module aie_dmem_model (
	input  wire logic                pclk,
	input  wire aie_pkg::aie_dmem_s  req,
	output logic [aie_pkg::DATA_W-1:0] rdata
);
	import aie_pkg::*;
	logic [DATA_W-1:0] mem [4096];

	initial
	begin
		for (int i = 0; i < 4096; i++)
			mem[i] = i[7:0] ^ 8'h3c;
	end

	// Combinational read of the held address
	assign rdata = mem[req.addr];

	always @(posedge pclk)
		if (req.we === 1'h1)
			mem[req.addr] <= req.wdata;
endmodule : aie_dmem_model

// ### aie_pkg.sv
// Constants, types and helpers shared by the add execute block
package aie_pkg;
	localparam int DATA_W  = 8;
	localparam int ADDR_W  = 12;
	localparam int INSTR_W = 16;
	localparam int BANK_W  = 4;
	localparam int APB_AW  = 8;
	localparam int QTR_CYC = 2;

	localparam logic [APB_AW-1:0] OFS_CTRL  = 8'h00;
	localparam logic [APB_AW-1:0] OFS_WORK  = 8'h04;
	localparam logic [APB_AW-1:0] OFS_FLAGS = 8'h08;
	localparam logic [APB_AW-1:0] OFS_BANK  = 8'h0c;
	localparam logic [APB_AW-1:0] OFS_IDX   = 8'h10;
	localparam logic [APB_AW-1:0] OFS_INSTR = 8'h14;
	localparam logic [APB_AW-1:0] OFS_STATE = 8'h18;

	localparam int CTRL_EXT_BIT = 0;
	localparam int CTRL_PSA_BIT = 1;
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_EXP2_BIT  = 1;
	localparam int ST_FLUSH_BIT = 2;
	localparam int BIT_D        = 9;
	localparam int BIT_A        = 8;

	localparam logic [1:0]         CTRL_RST  = 2'h0;
	localparam logic [DATA_W-1:0]  WORK_RST  = 8'h00;
	localparam logic [BANK_W-1:0]  BANK_RST  = 4'h0;
	localparam logic [ADDR_W-1:0]  IDX_RST   = 12'h000;
	localparam logic [INSTR_W-1:0] INSTR_RST = 16'h0000;

	localparam logic [7:0]  OPC_ADD_LIT  = 8'h0f;
	localparam logic [5:0]  OPC_ADD_FILE = 6'h09;
	localparam logic [3:0]  OPC_SECOND   = 4'hf;
	localparam logic [3:0]  OPC_RELJMP   = 4'hd;
	localparam logic [4:0]  OPC_BRCOND   = 5'h1c;
	localparam logic [6:0]  OPC_CALL     = 7'h76;
	localparam logic [7:0]  OPC_GOTO     = 8'hef;
	localparam logic [7:0]  OPC_LOAD_PTR = 8'hee;
	localparam logic [7:0]  OPC_RET_LIT  = 8'h0c;
	localparam logic [13:0] OPC_RETURN   = 14'h0004;

	localparam logic [7:0]        LOFS_MAX    = 8'h5f;
	localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hf;
	localparam logic [ADDR_W-1:0] PORT_ADDR   = 12'hf90;
	localparam logic [ADDR_W-1:0] TIMER_ADDR  = 12'hfa0;

	typedef struct packed {
		logic n;
		logic overflow_flag;
		logic z;
		logic digit_carry_flag;
		logic c;
	} aie_flags_s;

	localparam aie_flags_s FLAGS_RST = 5'h00;

	typedef struct packed {
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} aie_dmem_s;

	typedef enum logic [2:0] {
		CL_NOP, CL_ADD_LIT, CL_ADD_FILE, CL_PCJMP, CL_BRCOND, CL_TWO1ST,
		CL_OTHER
	} aie_class_e;

	typedef enum logic [2:0] {ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4} aie_state_e;

	function automatic aie_class_e aie_decode(input logic [INSTR_W-1:0] w);
		if (w[15:8] == OPC_ADD_LIT)
			return CL_ADD_LIT;
		else if (w[15:10] == OPC_ADD_FILE)
			return CL_ADD_FILE;
		else if (w[15:12] == OPC_SECOND)
			return CL_NOP;
		else if (w[15:9] == OPC_CALL || w[15:8] == OPC_GOTO ||
			w[15:8] == OPC_LOAD_PTR)
			return CL_TWO1ST;
		else if (w[15:12] == OPC_RELJMP || w[15:8] == OPC_RET_LIT ||
			w[15:2] == OPC_RETURN)
			return CL_PCJMP;
		else if (w[15:11] == OPC_BRCOND)
			return CL_BRCOND;
		else if (w == INSTR_RST)
			return CL_NOP;
		return CL_OTHER;
	endfunction : aie_decode

	function automatic logic aie_cond(input logic [2:0] cc,
		input aie_flags_s f);
		logic hit;
		unique case (cc[2:1])
			2'h0: hit = f.z;
			2'h1: hit = f.c;
			2'h2: hit = f.overflow_flag;
			2'h3: hit = f.n;
		endcase
		return hit ^ cc[0];
	endfunction : aie_cond

	function automatic logic [ADDR_W-1:0] aie_eff_addr(input logic ext,
		input logic a, input logic [7:0] f, input logic [BANK_W-1:0] bsr,
		input logic [ADDR_W-1:0] base);
		if (a)
			return {bsr, f};
		else if (ext && f <= LOFS_MAX)
			return ADDR_W'(base + ADDR_W'(f));
		else if (f <= LOFS_MAX)
			return {{BANK_W{1'b0}}, f};
		return {ACC_HI_BANK, f};
	endfunction : aie_eff_addr
endpackage : aie_pkg

// ### aie_qtr_div.sv
// Quarter phase tick divider for the instruction cycle
module aie_qtr_div (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic restart,
	output logic      q_tick
);
	import aie_pkg::*;

	localparam int CW = $clog2(QTR_CYC) + 1;
	localparam logic [CW-1:0] LAST = CW'(QTR_CYC - 1);

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;

	assign q_tick  = (cnt_r == LAST) && !restart;
	assign cnt_nxt = (restart || q_tick) ? '0 : CW'(cnt_r + 1'b1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end
endmodule : aie_qtr_div

// ### tb_add_instruction_execute.sv
// Self-checking bench for the add execute block
module tb_add_instruction_execute;
	timeunit 1ns;
	timeprecision 1ps;
	import aie_pkg::*;
	logic        pclk = 1'h0, presetn = 1'h0;
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00, port_pins = 8'h00, dmem_rdata;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'haf42;
	logic        pready, pslverr, timer_presc_clr, busy;
	aie_dmem_s   dmem_req;
	logic [7:0]  work;
	logic [4:0]  flags;
	logic [1:0]  ctrl;
	logic [3:0]  bank;
	logic [11:0] idx;
	int          mismatches = 0, check_count = 0, clr_cnt = 0;
	int          fb[4] = '{2, 0, 3, 4};

	aie_add_exec aie_add_exec_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_pins(port_pins),
		.dmem_rdata(dmem_rdata), .dmem_req(dmem_req),
		.timer_presc_clr(timer_presc_clr), .busy(busy));
	aie_dmem_model aie_dmem_model_i (.pclk(pclk), .req(dmem_req),
		.rdata(dmem_rdata));

	always #10 pclk = ~pclk;

	always @(posedge pclk)
		if (timer_presc_clr === 1'h1)
			clr_cnt++;

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Reference sum with the five flags above it
	function automatic logic [12:0] ref_add(input logic [7:0] a, b);
		logic [8:0] s;
		logic [4:0] h;
		s = a + b;
		h = a[3:0] + b[3:0];
		return {s[7], a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00,
			h[4], s[8], s[7:0]};
	endfunction : ref_add

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic s);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 50);
		if (pready !== 1'h1)
		begin
			mismatches++;
			conclude();
		end
		q = prdata;
		s = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        s;
		apb(1'h1, a, d, q, s);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		logic        s;
		apb(1'h0, a, 32'h0, q, s);
		check(q, e);
		check(32'(s), 32'h0);
	endtask : rd

	// Start an instruction and count its busy cycles
	task automatic exec(input logic [15:0] ins, input int cyc);
		int n;
		n = 0;
		wr(OFS_INSTR, 32'(ins));
		for (int k = 0; k < 100; k++)
		begin
			#1;
			if (busy === 1'h1)
				n++;
			else
				break;
			@(posedge pclk);
		end
		if (busy !== 1'h0)
		begin
			mismatches++;
			conclude();
		end
		if (cyc >= 0)
			check(n, cyc);
	endtask : exec

	task automatic add_work_to_file(input logic d, input logic a, input logic [7:0] f);
		logic [11:0] ea;
		logic [7:0]  op;
		logic [12:0] r;
		int          c0;
		if (a)
			ea = {bank, f};
		else if (ctrl[0] && f <= 8'h5f)
			ea = idx + {4'h0, f};
		else if (f <= 8'h5f)
			ea = {4'h0, f};
		else
			ea = {4'hf, f};
		op = (ea == PORT_ADDR) ? port_pins : aie_dmem_model_i.mem[ea];
		r = ref_add(work, op);
		c0 = clr_cnt;
		exec({OPC_ADD_FILE, d, a, f}, 8);
		flags = r[12:8];
		if (!d)
			work = r[7:0];
		rd(OFS_WORK, 32'(work));
		rd(OFS_FLAGS, 32'(flags));
		if (d)
			check(aie_dmem_model_i.mem[ea], r[7:0]);
		check(clr_cnt - c0, d && ea == TIMER_ADDR && ctrl[1]);
	endtask : add_work_to_file

	initial
	begin
		logic [31:0] v, q;
		logic [12:0] r;
		logic        s;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		for (int o = 0; o < 7; o++)
			rd(8'(o * 4), 32'h0);
		apb(1'h0, 8'h1c, 32'h0, q, s);
		check(s, 1'h1);
		check(q, 32'h0);
		for (int i = 0; i < 6; i++)
		begin
			v = rnd();
			work = v[7:0];
			wr(OFS_WORK, 32'(work));
			r = ref_add(work, v[15:8]);
			exec({OPC_ADD_LIT, v[15:8]}, 8);
			work = r[7:0];
			flags = r[12:8];
			rd(OFS_WORK, 32'(work));
			rd(OFS_FLAGS, 32'(flags));
		end
		for (int i = 0; i < 24; i++)
		begin
			v = rnd();
			ctrl = v[1:0];
			bank = v[5:2];
			idx = v[17:6];
			work = v[25:18];
			port_pins <= v[31:24];
			wr(OFS_CTRL, 32'(ctrl));
			wr(OFS_BANK, 32'(bank));
			wr(OFS_IDX, 32'(idx));
			wr(OFS_WORK, 32'(work));
			case (i % 4)
				1: add_work_to_file(v[8], 1'h0, 8'h90);
				2: add_work_to_file(1'h1, 1'h0, 8'ha0);
				3: add_work_to_file(v[9], v[10], 8'h5f);
				default: add_work_to_file(v[12], v[13], v[7:0] ^ v[31:24]);
			endcase
		end
		for (int cc = 0; cc < 8; cc++)
			exec({OPC_BRCOND, 3'(cc), 8'h04},
				(flags[fb[cc / 2]] ^ cc[0]) ? 16 : 8);
		exec(16'hd010, 16);
		exec(16'h0c22, 16);
		exec(16'h0012, 16);
		exec(16'hf123, 8);
		exec(16'hef00, 8);
		rd(OFS_STATE, 32'h2);
		exec(16'h0f33, 8);
		rd(OFS_WORK, 32'(work));
		rd(OFS_FLAGS, 32'(flags));
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		rd(OFS_WORK, 32'h0);
		rd(OFS_FLAGS, 32'h0);
		rd(OFS_STATE, 32'h0);
		conclude();
	end
endmodule : tb_add_instruction_execute
